// file: psr_pkg.sv
// package: address, bit positions and reset values of the pll status register
package psr_pkg;
	localparam logic [9:0] PSR_ADDR_PLL_STATUS = 10'h01F;
	localparam int PSR_BIT_LOCK = 0;
	localparam int PSR_BIT_REF_ONE_OK = 1;
	localparam int PSR_BIT_REF_TWO_OK = 2;
	localparam int PSR_BIT_VCO_OK = 3;
	localparam int PSR_BIT_REF_TWO_SEL = 4;
	localparam int PSR_BIT_HOLDOVER = 5;
	localparam int PSR_BIT_CAL_DONE = 6;
	localparam int PSR_NUM_SRC = 7;
	localparam logic [7:0] PSR_RESET_DATA = 8'h00;
	localparam logic [6:0] PSR_RESET_SYNC = 7'h00;
endpackage

// file: psr_sync.sv
// two-flop synchroniser bank for the status sources
`timescale 1ns/1ps
module psr_sync
	import psr_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [PSR_NUM_SRC-1:0] async_i,
	output logic [PSR_NUM_SRC-1:0] sync_o
);
	logic [PSR_NUM_SRC-1:0] meta_q;
	logic [PSR_NUM_SRC-1:0] sync_q;

	genvar g;
	generate
		for (g = 0; g < PSR_NUM_SRC; g++) begin : g_bit
			always_ff @(posedge sys_clk_i) begin
				if (!rst_n_i) begin
					meta_q[g] <= PSR_RESET_SYNC[g];
					sync_q[g] <= PSR_RESET_SYNC[g];
				end else begin
					meta_q[g] <= async_i[g];
					sync_q[g] <= meta_q[g];
				end
			end
		end
	endgenerate

	assign sync_o = sync_q;
endmodule

// file: psr_status.sv
// pll status readback register on the control port
`timescale 1ns/1ps
// Behaviour
// RQ1 - bit 4 high when reference two selected
// RQ2 - bit 3 high when oscillator above threshold
// RQ3 - bit 2 high when reference two above threshold
// RQ4 - bit 1 high when reference one above threshold
// RQ5 - bit 0 high while loop digitally locked
// RQ6 - bit 5 high only while in holdover
// RQ7 - bit 6 high once calibration finished
// RQ8 - writes ignored; read returns synchronised live state
module psr_status
	import psr_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [9:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reference_input_two_sel_i,
	input wire logic vco_above_thresh_i,
	input wire logic reference_input_two_ok_i,
	input wire logic reference_input_one_ok_i,
	input wire logic digital_lock_i,
	input wire logic holdover_active_i,
	input wire logic cal_done_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o
);
	logic [PSR_NUM_SRC-1:0] raw;
	logic [PSR_NUM_SRC-1:0] live;
	logic [7:0] status;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic hit;

	always_comb begin
		raw = '0;
		raw[PSR_BIT_LOCK] = digital_lock_i;
		raw[PSR_BIT_REF_ONE_OK] = reference_input_one_ok_i;
		raw[PSR_BIT_REF_TWO_OK] = reference_input_two_ok_i;
		raw[PSR_BIT_VCO_OK] = vco_above_thresh_i;
		raw[PSR_BIT_REF_TWO_SEL] = reference_input_two_sel_i;
		raw[PSR_BIT_HOLDOVER] = holdover_active_i;
		raw[PSR_BIT_CAL_DONE] = cal_done_i;
	end

	psr_sync u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(raw),
		.sync_o(live)
	);

	always_comb begin
		status = 8'h00;
		status[PSR_BIT_LOCK] = live[PSR_BIT_LOCK]; // [RQ5]
		status[PSR_BIT_REF_ONE_OK] = live[PSR_BIT_REF_ONE_OK]; // [RQ4]
		status[PSR_BIT_REF_TWO_OK] = live[PSR_BIT_REF_TWO_OK]; // [RQ3]
		status[PSR_BIT_VCO_OK] = live[PSR_BIT_VCO_OK]; // [RQ2]
		status[PSR_BIT_REF_TWO_SEL] = live[PSR_BIT_REF_TWO_SEL]; // [RQ1]
		status[PSR_BIT_HOLDOVER] = live[PSR_BIT_HOLDOVER]; // [RQ6]
		status[PSR_BIT_CAL_DONE] = live[PSR_BIT_CAL_DONE]; // [RQ7]
	end

	assign hit = (reg_addr_i == PSR_ADDR_PLL_STATUS);

	// read capture; writes have no effect on any state
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rdata_q <= PSR_RESET_DATA;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd_i; // [RQ8]
			if (reg_rd_i) begin
				rdata_q <= hit ? status : 8'h00; // [RQ8]
			end
		end
	end

	assign reg_rdata_o = rdata_q;
	assign reg_rvalid_o = rvalid_q;

	property p_rd_lock;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i && hit && $past(rst_n_i) && $past(rst_n_i, 2) |=>
		reg_rdata_o[PSR_BIT_LOCK] == $past(digital_lock_i, 3);
	endproperty
	a_rd_lock: assert property (p_rd_lock) // [RQ5]
		else $error("lock bit wrong");

	property p_rd_ref_one;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i && hit && $past(rst_n_i) && $past(rst_n_i, 2) |=>
		reg_rdata_o[PSR_BIT_REF_ONE_OK] == $past(reference_input_one_ok_i, 3);
	endproperty
	a_rd_ref_one: assert property (p_rd_ref_one) // [RQ4]
		else $error("reference one bit wrong");

	property p_rd_ref_two;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i && hit && $past(rst_n_i) && $past(rst_n_i, 2) |=>
		reg_rdata_o[PSR_BIT_REF_TWO_OK] == $past(reference_input_two_ok_i, 3);
	endproperty
	a_rd_ref_two: assert property (p_rd_ref_two) // [RQ3]
		else $error("reference two bit wrong");

	property p_rd_vco;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i && hit && $past(rst_n_i) && $past(rst_n_i, 2) |=>
		reg_rdata_o[PSR_BIT_VCO_OK] == $past(vco_above_thresh_i, 3);
	endproperty
	a_rd_vco: assert property (p_rd_vco) // [RQ2]
		else $error("vco bit wrong");

	property p_rd_sel;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i && hit && $past(rst_n_i) && $past(rst_n_i, 2) |=>
		reg_rdata_o[PSR_BIT_REF_TWO_SEL] == $past(reference_input_two_sel_i, 3);
	endproperty
	a_rd_sel: assert property (p_rd_sel) // [RQ1]
		else $error("select bit wrong");

	property p_rd_hold;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i && hit && $past(rst_n_i) && $past(rst_n_i, 2) |=>
		reg_rdata_o[PSR_BIT_HOLDOVER] == $past(holdover_active_i, 3);
	endproperty
	a_rd_hold: assert property (p_rd_hold) // [RQ6]
		else $error("holdover bit wrong");

	property p_rd_cal;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i && hit && $past(rst_n_i) && $past(rst_n_i, 2) |=>
		reg_rdata_o[PSR_BIT_CAL_DONE] == $past(cal_done_i, 3);
	endproperty
	a_rd_cal: assert property (p_rd_cal) // [RQ7]
		else $error("cal bit wrong");

	property p_wr_ignored;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_wr_i && !reg_rd_i |=> $stable(reg_rdata_o) && !reg_rvalid_o;
	endproperty
	a_wr_ignored: assert property (p_wr_ignored) // [RQ8]
		else $error("write changed data");

	property p_wr_during_rd;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i && reg_wr_i && hit && $past(rst_n_i) && $past(rst_n_i, 2)
		|=> reg_rdata_o == {1'b0, $past(raw, 3)};
	endproperty
	a_wr_during_rd: assert property (p_wr_during_rd) // [RQ8]
		else $error("write disturbed read data");

	property p_top_zero;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rvalid_o |-> reg_rdata_o[7] == 1'b0;
	endproperty
	a_top_zero: assert property (p_top_zero) // [RQ8]
		else $error("bit 7 not zero");

	property p_rd_answer;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i |=> reg_rvalid_o;
	endproperty
	a_rd_answer: assert property (p_rd_answer) // [RQ8]
		else $error("read not answered");

	property p_idle_quiet;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		!reg_rd_i |=> !reg_rvalid_o && $stable(reg_rdata_o);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) // [RQ8]
		else $error("answer without read");

	property p_rd_unmapped;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i && !hit |=> reg_rdata_o == 8'h00;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) // [RQ8]
		else $error("unmapped read not zero");

	property p_rst_values;
		@(posedge sys_clk_i)
		!rst_n_i |=> reg_rdata_o == PSR_RESET_DATA && !reg_rvalid_o;
	endproperty
	a_rst_values: assert property (p_rst_values) // [RQ8]
		else $error("reset values wrong");

	property p_live_sync;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		$past(rst_n_i) && $past(rst_n_i, 2) |-> live == $past(raw, 2);
	endproperty
	a_live_sync: assert property (p_live_sync) // [RQ8]
		else $error("synchroniser path wrong");

	property p_cv_read_locked;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i && hit ##1 reg_rdata_o[PSR_BIT_LOCK];
	endproperty
	c_read_locked: cover property (p_cv_read_locked);

	property p_cv_read_holdover;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i && hit ##1 reg_rdata_o[PSR_BIT_HOLDOVER];
	endproperty
	c_read_holdover: cover property (p_cv_read_holdover);

	property p_cv_write;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_wr_i && hit;
	endproperty
	c_write: cover property (p_cv_write);

	property p_cv_unmapped;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i && !hit;
	endproperty
	c_unmapped: cover property (p_cv_unmapped);

	property p_cv_back_to_back;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_rd_i ##1 reg_rd_i;
	endproperty
	c_back_to_back: cover property (p_cv_back_to_back);
endmodule

// file: tb_top.sv
// self-checking testbench for the pll status readback register
`timescale 1ns/1ps
module tb_top;
	import psr_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [9:0] reg_addr_i = 10'h000;
	logic reg_rd_i = 1'b0;
	logic reg_wr_i = 1'b0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [6:0] src = 7'h00;
	logic [7:0] reg_rdata_o;
	logic reg_rvalid_o;
	logic [9:0] a [2];
	logic [7:0] last = 8'h00;
	logic [7:0] exp_q [$];
	int hist_q [$];
	int fail_count = 0;
	int n_checks = 0;
	integer seed = 32'h4743;
	psr_status dut (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i),
		.reg_rd_i(reg_rd_i),
		.reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i),
		.reference_input_two_sel_i(src[PSR_BIT_REF_TWO_SEL]),
		.vco_above_thresh_i(src[PSR_BIT_VCO_OK]),
		.reference_input_two_ok_i(src[PSR_BIT_REF_TWO_OK]),
		.reference_input_one_ok_i(src[PSR_BIT_REF_ONE_OK]),
		.digital_lock_i(src[PSR_BIT_LOCK]),
		.holdover_active_i(src[PSR_BIT_HOLDOVER]),
		.cal_done_i(src[PSR_BIT_CAL_DONE]),
		.reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o)
	);
	initial begin
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	// model: status byte at its address, zero elsewhere, bit 7 zero
	function automatic logic [7:0] model(input logic [9:0] ad, input int st);
		return (ad == PSR_ADDR_PLL_STATUS) ? {1'b0, 7'(st)} : 8'h00;
	endfunction
	// model: a source change reaches a read two edges later
	always @(posedge sys_clk_i) begin
		if (rst_n_i && reg_rd_i && hist_q.size() == 2)
			exp_q.push_back(model(reg_addr_i, hist_q[0]));
		hist_q.push_back(int'(src));
		if (hist_q.size() > 2)
			void'(hist_q.pop_front());
	end
	task automatic chk(input string nm, input logic [7:0] seen,
			input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fail_count++;
		end_sim;
	end
	initial begin
		repeat (5) @(negedge sys_clk_i);
		chk("rvalid_rst", {7'h00, reg_rvalid_o}, 8'h00);
		chk("rdata_rst", reg_rdata_o, PSR_RESET_DATA);
		rst_n_i = 1'b1;
		for (int i = 0; i < 60; i++) begin
			src = 7'($random(seed));
			reg_wr_i = 1'b1;
			reg_wdata_i = 8'($random(seed));
			reg_addr_i = PSR_ADDR_PLL_STATUS;
			repeat (1 + ($random(seed) & 3)) @(negedge sys_clk_i);
			for (int k = 0; k < 2; k++) begin
				a[k] = 10'($random(seed));
				if ($random(seed) & 1)
					a[k] = PSR_ADDR_PLL_STATUS;
			end
			reg_wr_i = 1'($random(seed));
			reg_rd_i = 1'b1;
			reg_addr_i = a[0];
			for (int k = 0; k < 2; k++) begin
				@(negedge sys_clk_i);
				chk("rvalid", {7'h00, reg_rvalid_o}, 8'(exp_q.size()));
				if (exp_q.size() > 0)
					last = exp_q.pop_front();
				chk("rdata", reg_rdata_o, last);
				reg_addr_i = a[1];
				reg_wdata_i = 8'($random(seed));
				src = 7'($random(seed));
			end
			reg_rd_i = 1'b0;
			@(negedge sys_clk_i);
			chk("rvalid_low", {7'h00, reg_rvalid_o}, 8'(exp_q.size()));
			chk("rdata_hold", reg_rdata_o, last);
		end
		end_sim;
	end
endmodule
